//--- pkg/asd_pkg.sv
// Constants and types for the serial sampling converter sequencer
package asd_pkg;

   // ****************************************
   // Sizes and counts
   // ****************************************
   localparam int ASD_RES_BITS = 8;
   localparam logic [2:0] ASD_WORD_BITS = 3'h4; // Config plus dummy bits after start
   localparam logic [2:0] ASD_SEL_IDX = 3'h0; // Word position of single-ended select
   localparam logic [2:0] ASD_POL_IDX = 3'h1; // Word position of polarity select
   localparam logic [3:0] ASD_LAST_RISE = 4'h8; // Rise count before the conversion ends
   localparam logic [3:0] ASD_MSB_RISE = 4'h1; // Rise count at which the MSB is launched
   localparam logic [3:0] ASD_ACQ_RISES = 4'h2; // Rising edges inside the 2.5 cycle window
   localparam logic [7:0] ASD_MASK_MSB = 8'h80;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] ASD_RES_RST = 8'h00;
   localparam logic [3:0] ASD_CNT_RST = 4'h0;
   localparam logic [1:0] ASD_SYNC_RST = 2'h3; // Chip select idles high

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      ASD_WAIT = 4'h1,
      ASD_WORD = 4'h2,
      ASD_CONV = 4'h4,
      ASD_DONE = 4'h8
   } asd_state_t;

endpackage

//--- hdl/asd_adc_serial_core.sv
// Serial sequencer of the 8-bit sampling converter with chip select shutdown
`timescale 1ns/100ps
`default_nettype none
module asd_adc_serial_core
   import asd_pkg::*;
#(
   parameter bit MUX_VARIANT = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial pins from the host
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic sdin_pin,
   // Serial data output pin
   output logic sdout,
   output logic sdout_oe,
   // Analog core
   input wire logic cmp_hi,
   output logic [7:0] sar_trial,
   output logic powered,
   output logic acquiring,
   output logic holding,
   output logic single_ended_select,
   output logic channel_polarity_select,
   // Result
   output logic [7:0] result,
   output logic result_valid
);

   // ****************************************
   // Pin synchronisers and edge detection
   // ****************************************
   logic [1:0] cs_sync_r;
   logic [1:0] sclk_sync_r;
   logic [1:0] sdin_sync_r;
   logic sclk_prev_r;
   logic cs_q;
   logic sdin_q;
   logic rise;
   logic fall;

   // Two stages each; only the second stage is looked at
   always_ff @(posedge clk) begin
      if (rst) begin
         cs_sync_r <= ASD_SYNC_RST;
         sclk_sync_r <= 2'h0;
         sdin_sync_r <= 2'h0;
         sclk_prev_r <= 1'b0;
      end else begin
         cs_sync_r <= {cs_sync_r[0], cs_n_pin};
         sclk_sync_r <= {sclk_sync_r[0], sclk_pin};
         sdin_sync_r <= {sdin_sync_r[0], sdin_pin};
         sclk_prev_r <= sclk_sync_r[1];
      end
   end

   // Data and clock share latency, so sampled data lines up with its edge
   assign cs_q = cs_sync_r[1];
   assign sdin_q = sdin_sync_r[1];
   assign rise = sclk_sync_r[1] & ~sclk_prev_r;
   assign fall = ~sclk_sync_r[1] & sclk_prev_r;

   // ****************************************
   // Sequencer
   // ****************************************
   asd_state_t state_r;
   logic [2:0] word_cnt_r;
   logic [3:0] rc_r;
   logic [7:0] res_r;
   logic [7:0] mask_r;
   logic hold_start;
   logic conv_end;

   // Hold begins on the falling edge after the last dummy bit, or for the
   // fixed variant on the first falling edge of the frame
   assign hold_start = !cs_q && fall &&
      ((state_r == ASD_WORD && word_cnt_r == ASD_WORD_BITS) ||
       (!MUX_VARIANT && state_r == ASD_WAIT));
   assign conv_end = !cs_q && rise && state_r == ASD_CONV && rc_r == ASD_LAST_RISE;

   // Chip select high parks everything, so clock and data may keep running
   always_ff @(posedge clk) begin
      if (rst || cs_q) begin
         state_r <= ASD_WAIT;
      end else begin
         unique case (state_r)
            ASD_WAIT: begin
               if (MUX_VARIANT && rise && sdin_q) begin
                  state_r <= ASD_WORD;
               end else if (hold_start) begin
                  state_r <= ASD_CONV;
               end
            end
            ASD_WORD: begin
               if (hold_start) begin
                  state_r <= ASD_CONV;
               end
            end
            ASD_CONV: begin
               if (conv_end) begin
                  state_r <= ASD_DONE;
               end
            end
            ASD_DONE: begin
               state_r <= ASD_DONE; // Further input ignored until chip select rises
            end
         endcase
      end
   end

   // Input word capture; bits after the word are not looked at
   always_ff @(posedge clk) begin
      if (rst || cs_q) begin
         word_cnt_r <= 3'h0;
         single_ended_select <= 1'b0;
         channel_polarity_select <= 1'b0;
      end else if (state_r == ASD_WORD && rise && word_cnt_r != ASD_WORD_BITS) begin
         word_cnt_r <= word_cnt_r + 3'h1;
         if (word_cnt_r == ASD_SEL_IDX) begin
            single_ended_select <= sdin_q;
         end
         if (word_cnt_r == ASD_POL_IDX) begin
            channel_polarity_select <= sdin_q;
         end
      end
   end

   // ****************************************
   // Sample and hold control
   // ****************************************
   logic [3:0] acq_rises_r;

   // Multiplexed: window opens as polarity bit enters; fixed: open while selected and outside conversion
   always_ff @(posedge clk) begin
      if (rst || cs_q) begin
         acquiring <= 1'b0;
      end else if (hold_start) begin
         acquiring <= 1'b0;
      end else if (MUX_VARIANT) begin
         if (state_r == ASD_WORD && rise && word_cnt_r == ASD_POL_IDX) begin
            acquiring <= 1'b1;
         end
      end else if (state_r != ASD_CONV) begin
         acquiring <= 1'b1;
      end
   end

   // Rising edges seen inside the window, for checking its length
   always_ff @(posedge clk) begin
      if (rst || !acquiring) begin
         acq_rises_r <= ASD_CNT_RST;
      end else if (rise) begin
         acq_rises_r <= acq_rises_r + 4'h1;
      end
   end

   assign holding = state_r == ASD_CONV;
   assign powered = !cs_q;

   // ****************************************
   // Successive approximation
   // ****************************************
   // Decide one bit per falling edge so it is ready for the next rising edge
   always_ff @(posedge clk) begin
      if (rst || cs_q) begin
         res_r <= ASD_RES_RST;
         mask_r <= 8'h00;
      end else if (hold_start) begin
         res_r <= ASD_RES_RST;
         mask_r <= ASD_MASK_MSB;
      end else if (holding && fall && mask_r != 8'h00) begin
         if (cmp_hi) begin
            res_r <= res_r | mask_r;
         end
         mask_r <= mask_r >> 1;
      end
   end

   // Trial code shown to the comparator; settles only between clock edges
   assign sar_trial = res_r | mask_r;

   // Rising edges since hold; the first is the second null bit
   always_ff @(posedge clk) begin
      if (rst || cs_q || hold_start) begin
         rc_r <= ASD_CNT_RST;
      end else if (holding && rise) begin
         rc_r <= rc_r + 4'h1;
      end
   end

   // Finished result held until the next conversion
   always_ff @(posedge clk) begin
      if (rst) begin
         result <= ASD_RES_RST;
         result_valid <= 1'b0;
      end else begin
         result_valid <= conv_end;
         if (conv_end) begin
            result <= res_r;
         end
      end
   end

   // ****************************************
   // Serial output
   // ****************************************
   logic upd_ev;

   // Drive starts low at hold; later bits change only on rising edges
   always_ff @(posedge clk) begin
      if (rst || cs_q) begin
         sdout <= 1'b0;
         sdout_oe <= 1'b0;
      end else if (hold_start) begin
         sdout <= 1'b0;
         sdout_oe <= 1'b1;
      end else if (rise && holding && rc_r >= ASD_MSB_RISE) begin
         sdout <= res_r[3'(4'(ASD_RES_BITS) - rc_r)];
      end else if (rise) begin
         sdout <= 1'b0;
      end
   end

   assign upd_ev = rise || hold_start || cs_q;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_power_down_quiet: assert property (cs_q |-> !powered ##1 (!sdout_oe && !acquiring))
      else $error("device active while chip select high");
   a_ignore_when_off: assert property (cs_q && rise && sdin_q |=> state_r == ASD_WAIT)
      else $error("serial activity acted on while powered down");
   a_abandon_conv: assert property (holding && cs_q |=> !holding && !sdout_oe)
      else $error("conversion survived chip select high");
   a_skip_zeros: assert property (MUX_VARIANT && !cs_q && state_r == ASD_WAIT && rise
      && !sdin_q |=> state_r == ASD_WAIT)
      else $error("zero taken as start bit");
   a_acq_opens: assert property (MUX_VARIANT && !cs_q && state_r == ASD_WORD && rise
      && word_cnt_r == ASD_POL_IDX |=> acquiring)
      else $error("acquisition did not open with polarity bit");
   a_acq_length: assert property (MUX_VARIANT && hold_start |-> acq_rises_r == ASD_ACQ_RISES)
      else $error("acquisition window length wrong");
   a_hold_entry: assert property (hold_start |=> holding && !acquiring && sdout_oe && !sdout)
      else $error("hold did not start on final falling edge");
   a_conv_finish: assert property (holding && rise && !cs_q && rc_r == ASD_LAST_RISE
      |=> !holding && result_valid)
      else $error("conversion length wrong");
   a_one_decision: assert property (holding && fall && !cs_q && mask_r != 8'h00
      |=> mask_r == ($past(mask_r) >> 1))
      else $error("bit decision cadence wrong");
   a_null_bits: assert property (holding && rc_r <= ASD_MSB_RISE && !$past(rise) |-> !sdout)
      else $error("null bit not low");
   a_tail_zeros: assert property (state_r == ASD_DONE && rise |=> !sdout)
      else $error("output not zero after result");
   a_out_on_rise: assert property ($changed(sdout) |-> $past(upd_ev))
      else $error("serial output changed off a rising edge");
   a_fixed_acq: assert property (!MUX_VARIANT && state_r == ASD_DONE
      && $past(state_r) == ASD_DONE |-> acquiring)
      else $error("fixed variant not acquiring after conversion");

endmodule // asd_adc_serial_core
`default_nettype wire

//--- dv/asd_host_model.sv
// Host controller model driving the converter's serial pins
`timescale 1ns/100ps
`default_nettype none
module asd_host_model (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic cs_n_pin,
   output logic sclk_pin,
   output logic sdin_pin,
   input wire logic sdout
);
   logic [31:0] bits; // Output bit seen at each rise
   // Pins idle with chip select released
   initial begin
      cs_n_pin = 1'b1;
      sclk_pin = 1'b0;
      sdin_pin = 1'b0;
   end
   // Half a serial clock is 4 clk: 2.5 MHz, well below the supply limit
   task automatic half(input logic lvl);
      repeat (4) @(posedge clk);
      sclk_pin <= lvl;
   endtask
   // One exchange; past the word the input toggles, which must be ignored
   task automatic frame(input int lead, input logic [3:0] word, input int n);
      logic [4:0] seq;
      seq = {1'b1, word};
      cs_n_pin <= 1'b0;
      for (int i = 0; i < n; i++) begin
         sdin_pin <= (i < lead) ? 1'b0 : (i <= lead + 4) ? seq[lead + 4 - i] : i[0];
         half(1'b1);
         bits[i] = sdout;
         half(1'b0);
      end
      repeat (4) @(posedge clk);
      cs_n_pin <= 1'b1;
   endtask
   // Pins keep running while deselected
   task automatic idle(input int n);
      for (int i = 0; i < n; i++) begin
         sdin_pin <= 1'b1;
         half(1'b1);
         sdin_pin <= i[0];
         half(1'b0);
      end
   endtask
endmodule // asd_host_model
`default_nettype wire

//--- dv/asd_adc_serial_core_tb.sv
// Self-checking bench for the serial converter sequencer
`timescale 1ns/100ps
`default_nettype none
module asd_adc_serial_core_tb;
   logic clk, rst, cs_n_pin, sclk_pin, sdin_pin, sdout, sdout_oe, cmp_hi;
   logic powered, acquiring, holding, sel, pol, result_valid, sel_seen, pol_seen;
   logic [7:0] sar_trial, result, vin, res_seen;
   int errors = 0, n_tests = 0, cycles = 0;
   int acq_cnt, hold_cnt, rv_cnt, pw_cnt, oe_cnt;
   // Fixed differential instance shares the host's pins
   logic sdout_f, cmp_f, acquiring_f, holding_f;
   logic [7:0] trial_f, result_f;
   logic [31:0] fbits;
   int acq_fc, hold_fc, fi;

   asd_adc_serial_core i_asd_adc_serial_core (
      .clk(clk), .rst(rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdin_pin(sdin_pin),
      .sdout(sdout), .sdout_oe(sdout_oe), .cmp_hi(cmp_hi), .sar_trial(sar_trial),
      .powered(powered), .acquiring(acquiring), .holding(holding),
      .single_ended_select(sel), .channel_polarity_select(pol), .result(result),
      .result_valid(result_valid)
   );
   asd_host_model i_asd_host_model (
      .clk(clk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdin_pin(sdin_pin), .sdout(sdout)
   );
   asd_adc_serial_core #(
      .MUX_VARIANT(1'b0)
   ) i_asd_adc_serial_core_fixed (
      .clk(clk), .rst(rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdin_pin(sdin_pin),
      .sdout(sdout_f), .sdout_oe(), .cmp_hi(cmp_f), .sar_trial(trial_f), .powered(),
      .acquiring(acquiring_f), .holding(holding_f), .single_ended_select(),
      .channel_polarity_select(), .result(result_f), .result_valid()
   );

   // ****************************************
   // Clock, analog stand-in and monitors
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Ideal comparator, so a correct search returns vin exactly
   always @(posedge clk) cmp_hi <= (vin >= sar_trial);
   always @(posedge clk) cmp_f <= (vin >= trial_f);
   // Fixed output as the host would capture it, one entry per serial rise
   always @(posedge sclk_pin) begin
      fbits[fi] = sdout_f;
      fi++;
   end
   // Counters sample once a clk, so window lengths come out in clk cycles
   always @(posedge clk) begin
      cycles++;
      acq_cnt += (acquiring === 1'b1);
      hold_cnt += (holding === 1'b1);
      pw_cnt += (powered === 1'b1);
      oe_cnt += (sdout_oe === 1'b1);
      acq_fc += (acquiring_f === 1'b1);
      hold_fc += (holding_f === 1'b1);
      if (result_valid === 1'b1) begin
         rv_cnt++;
         res_seen = result;
         sel_seen = sel;
         pol_seen = pol;
      end
      if (cycles == 3000) begin
         errors++;
         print_verdict;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   // Called only while deselected and idle, so no count races the clear
   task automatic clr;
      {acq_cnt, hold_cnt, rv_cnt, pw_cnt, oe_cnt, acq_fc, hold_fc, fi} = '0;
      {res_seen, sel_seen, pol_seen} = 'x;
   endtask
   task automatic t_reset;
      chk({powered, sdout_oe, acquiring, holding}, 0);
      chk(result, 0);
   endtask
   task automatic t_idle;
      clr;
      i_asd_host_model.idle(12);
      repeat (6) @(posedge clk);
      chk(pw_cnt, 0);
      chk(acq_cnt + oe_cnt + rv_cnt + acq_fc + hold_fc, 0);
   endtask
   task automatic t_conv(input int lead, input logic [3:0] word, input logic [7:0] v);
      logic e;
      vin = v;
      clr;
      i_asd_host_model.frame(lead, word, lead + 18);
      repeat (6) @(posedge clk);
      // Null at rises 5 and 6 after start, data MSB first, then zeros
      for (int i = lead + 5; i < lead + 18; i++) begin
         e = (i > lead + 6 && i < lead + 15) ? v[lead + 14 - i] : 1'b0;
         chk(i_asd_host_model.bits[i], e);
      end
      chk(res_seen, v);
      chk({sel_seen, pol_seen}, word[3:2]);
      chk(acq_cnt, 20);
      chk(hold_cnt, 68);
      chk(rv_cnt, 1);
      chk(pw_cnt, 8 * (lead + 18) + 4);
      chk(oe_cnt, 108);
      // Fixed variant: hold at the first fall, nulls at rises 1 and 2, data at 3 to 10
      chk(result_f, v);
      chk(acq_fc, 8 * lead + 79);
      chk(hold_fc, 68);
      for (int i = 1; i < 14; i++) begin
         e = (i > 2 && i < 11) ? v[10 - i] : 1'b0;
         chk(fbits[i], e);
      end
      chk({powered, sdout_oe, sel, pol, holding, acquiring_f, holding_f}, 0);
   endtask
   // Deselect in mid-conversion; the next exchange shows recovery
   task automatic t_abort;
      logic [7:0] keep, keep_f;
      keep = result;
      keep_f = result_f;
      clr;
      i_asd_host_model.frame(0, 4'hC, 9);
      repeat (6) @(posedge clk);
      chk({holding, holding_f, sdout_oe, sel, rv_cnt != 0}, 0);
      chk(result, keep);
      chk(result_f, keep_f);
   endtask

   task automatic print_verdict;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      vin = 8'h00;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_reset;
      t_idle;
      t_conv(0, 4'hC, 8'hA5);
      t_conv(3, 4'h9, 8'hFF);
      t_conv(1, 4'h6, 8'h00);
      t_conv(2, 4'h3, 8'h5A);
      t_abort;
      t_conv(0, 4'hE, 8'h81);
      print_verdict;
   end
endmodule // asd_adc_serial_core_tb
`default_nettype wire
